// ### hdl/pin_select_pkg.sv
// Shared constants for the reset pin and low port A pin selection block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package pin_select_pkg;

  // Register byte offsets
  localparam int unsigned    ADDR_W          = 5;
  localparam logic [4:0]     OFS_DIR         = 5'h00;
  localparam logic [4:0]     OFS_DATA_OUT    = 5'h04;
  localparam logic [4:0]     OFS_DATA_IN     = 5'h08;
  localparam logic [4:0]     OFS_FUNC_SEL    = 5'h0C;
  localparam logic [4:0]     OFS_RST_PIN_CFG = 5'h10;
  localparam logic [4:0]     OFS_FAULT_MAP   = 5'h14;
  localparam logic [4:0]     OFS_STATUS      = 5'h18;
  localparam logic [4:0]     OFS_SW_RESET    = 5'h1C;

  // Widths and field positions
  localparam int unsigned    LOW_PINS        = 5;
  localparam int unsigned    PULSE_CH        = 6;
  localparam int unsigned    FUNC_W          = 2;
  localparam int unsigned    TIMER_PIN       = 4;
  localparam int unsigned    RST_PIN_BIT     = 7;
  localparam logic [7:0]     PORT_MASK       = 8'h9F;
  localparam int unsigned    CFG_GPIO_BIT    = 0;
  localparam int unsigned    SW_RESET_BIT    = 0;
  localparam int unsigned    ST_FAULT_BIT    = 0;
  localparam int unsigned    ST_PIN_LVL_BIT  = 1;
  localparam int unsigned    ST_CAUSE_LSB    = 4;
  localparam int unsigned    CAUSE_W         = 4;

  // Reset values
  localparam logic [7:0]     DIR_RST         = 8'h00;
  localparam logic [7:0]     DATA_OUT_RST    = 8'h00;
  localparam logic [5:0]     FAULT_MAP_RST   = 6'h00;
  localparam logic           CFG_GPIO_RST    = 1'b0;
  localparam logic [3:0]     CAUSE_RST       = 4'h1;

  // Timing: internal clocks that reset stays asserted after all sources go away
  localparam int unsigned    RESET_HOLD_CYCLES = 32;

  // Cause bits inside the cause field
  localparam int unsigned    CAUSE_POR       = 0;
  localparam int unsigned    CAUSE_PIN       = 1;
  localparam int unsigned    CAUSE_WDOG      = 2;
  localparam int unsigned    CAUSE_SW        = 3;

  typedef enum logic [1:0] {
    FUNC_GPIO,
    FUNC_PULSE,
    FUNC_TIMER,
    FUNC_FAULT
  } pin_func_t;

endpackage

// ### hdl/reset_stretch.sv
// Internal reset generator: holds reset while any source is active, then
// a fixed number of clocks more. Assumes req_i is synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none

module reset_stretch #(
  parameter int unsigned HOLD_CYCLES = pin_select_pkg::RESET_HOLD_CYCLES
) (
  // Clock and power-on reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Reset request and stretched reset
  input  wire logic req_i,
  output logic      rst_n_o
);
  import pin_select_pkg::*;

  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HOLD_CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;

  // Release is counted in clocks, so deassertion is synchronous
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r   <= '0;
      rst_n_o <= 1'b0;
    end else if (req_i) begin
      cnt_r   <= '0;
      rst_n_o <= 1'b0;
    end else if (!rst_n_o) begin
      if (cnt_r == CNT_LAST) begin
        rst_n_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// ### hdl/reset_and_port_a_pin_select.sv
// Pin function selection for the shared reset pin and port A bits 0..4,
// with the chip reset sequencer behind the reset pin.
// Assumes pad levels and peripheral signals are synchronous to clk_i and
// that pads resolve each pin from its output and active-low output enable.
`timescale 1ns/10ps
`default_nettype none

module reset_and_port_a_pin_select #(
  parameter int unsigned HOLD_CYCLES  = pin_select_pkg::RESET_HOLD_CYCLES,
  parameter logic        FAULT_ACTIVE = 1'b1
) (
  // Clock and power-on reset
  input  wire logic                               clk_i,
  input  wire logic                               arst_n_i,
  // Avalon-MM slave
  input  wire logic [pin_select_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                               avs_read_i,
  input  wire logic                               avs_write_i,
  input  wire logic [31:0]                        avs_writedata_i,
  input  wire logic [3:0]                         avs_byteenable_i,
  output logic      [31:0]                        avs_readdata_o,
  output logic                                    avs_waitrequest_o,
  // Reset pin, shared with port A bit 7
  input  wire logic                               reset_pin_port_bit_i,
  output logic                                    reset_pin_port_bit_o,
  output logic                                    reset_pin_port_bit_oe_n_o,
  // Other reset sources and the internal reset
  input  wire logic                               watchdog_reset_i,
  output logic                                    sys_rst_n_o,
  // Port A bits 0..4 pads
  input  wire logic [pin_select_pkg::LOW_PINS-1:0] port_a_pin_i,
  output logic      [pin_select_pkg::LOW_PINS-1:0] port_a_pin_o,
  output logic      [pin_select_pkg::LOW_PINS-1:0] port_a_pin_oe_n_o,
  // Pulse generator side
  input  wire logic [pin_select_pkg::PULSE_CH-1:0] pulse_out_i,
  output logic      [pin_select_pkg::PULSE_CH-1:0] pulse_fault_o,
  // Timer A channel 2 side
  input  wire logic                               timer_a_channel_two_out_i,
  input  wire logic                               timer_a_channel_two_oe_i,
  output logic                                    timer_a_channel_two_in_o,
  // Fault input one as seen by the pulse generator
  output logic                                    offchip_fault_input_one_o
);
  import pin_select_pkg::*;

  // Configuration state
  logic [7:0]              dir_r;
  logic [7:0]              data_out_r;
  logic [7:0]              data_in_r;
  pin_func_t               func_r [LOW_PINS];
  logic                    cfg_gpio_r;
  logic [PULSE_CH-1:0]     fault_map_r;
  logic                    fault_st_r;
  logic [CAUSE_W-1:0]      cause_r;
  logic                    sw_rst_r;

  // Bus helpers
  logic                    bus_req;
  logic                    commit;
  logic [31:0]             rd_word;
  logic [31:0]             wmerge;

  // Reset and fault helpers
  logic                    pin_rst_req;
  logic                    rst_req;
  logic                    fault_raw;
  logic [CAUSE_W-1:0]      cause_set;
  logic [CAUSE_W-1:0]      cause_clr;

  // Reset sequencing

  // The pin counts as a reset source only in its reset role
  assign pin_rst_req = !cfg_gpio_r && !reset_pin_port_bit_i;
  assign rst_req     = pin_rst_req || watchdog_reset_i || sw_rst_r;

  reset_stretch #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_reset_stretch (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .req_i    (rst_req),
    .rst_n_o  (sys_rst_n_o)
  );

  // Avalon-MM slave: one wait state on every access

  assign bus_req = avs_read_i || avs_write_i;
  assign commit  = avs_write_i && !avs_waitrequest_o;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_word;
    end
  end

  // Readback of the addressed register; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address_i)
      OFS_DIR:      rd_word[7:0] = dir_r & PORT_MASK;
      OFS_DATA_OUT: rd_word[7:0] = data_out_r & PORT_MASK;
      OFS_DATA_IN:  rd_word[7:0] = data_in_r & PORT_MASK;
      OFS_FUNC_SEL: begin
        for (int k = 0; k < LOW_PINS; k++) begin
          rd_word[FUNC_W*k +: FUNC_W] = func_r[k];
        end
      end
      OFS_RST_PIN_CFG: rd_word[CFG_GPIO_BIT] = cfg_gpio_r;
      OFS_FAULT_MAP:   rd_word[PULSE_CH-1:0] = fault_map_r;
      OFS_STATUS: begin
        rd_word[ST_FAULT_BIT]                  = fault_st_r;
        rd_word[ST_PIN_LVL_BIT]                = data_in_r[RST_PIN_BIT];
        rd_word[ST_CAUSE_LSB +: CAUSE_W]       = cause_r;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Byte lanes not enabled keep the register's present contents, except status lane 0, whose set cause bits are cleared
  always_comb begin
    wmerge = rd_word;
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable_i[b]) begin
        wmerge[8*b +: 8] = avs_writedata_i[8*b +: 8];
      end
    end
  end

  // Configuration registers, cleared by power-on and internal reset

  // Direction, one independent bit per pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_r <= DIR_RST;
    end else if (!sys_rst_n_o) begin
      dir_r <= DIR_RST;
    end else if (commit && avs_address_i == OFS_DIR) begin
      dir_r <= wmerge[7:0] & PORT_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_out_r <= DATA_OUT_RST;
    end else if (!sys_rst_n_o) begin
      data_out_r <= DATA_OUT_RST;
    end else if (commit && avs_address_i == OFS_DATA_OUT) begin
      data_out_r <= wmerge[7:0] & PORT_MASK;
    end
  end

  // Function selects held here, not in the peripherals
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < LOW_PINS; k++) begin
        func_r[k] <= FUNC_GPIO;
      end
    end else if (!sys_rst_n_o) begin
      for (int k = 0; k < LOW_PINS; k++) begin
        func_r[k] <= FUNC_GPIO;
      end
    end else if (commit && avs_address_i == OFS_FUNC_SEL) begin
      for (int k = 0; k < LOW_PINS; k++) begin
        func_r[k] <= pin_func_t'(wmerge[FUNC_W*k +: FUNC_W]);
      end
    end
  end

  // Reset pin role: any reset brings it back to reset input
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_gpio_r <= CFG_GPIO_RST;
    end else if (!sys_rst_n_o) begin
      cfg_gpio_r <= CFG_GPIO_RST;
    end else if (commit && avs_address_i == OFS_RST_PIN_CFG) begin
      cfg_gpio_r <= wmerge[CFG_GPIO_BIT];
    end
  end

  // Pulse channels that fault input one shuts off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_map_r <= FAULT_MAP_RST;
    end else if (!sys_rst_n_o) begin
      fault_map_r <= FAULT_MAP_RST;
    end else if (commit && avs_address_i == OFS_FAULT_MAP) begin
      fault_map_r <= wmerge[PULSE_CH-1:0];
    end
  end

  // Software reset request, one clock wide
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_rst_r <= 1'b0;
    end else begin
      sw_rst_r <= commit && avs_address_i == OFS_SW_RESET && wmerge[SW_RESET_BIT];
    end
  end

  // Reset cause, sticky across internal reset; write one to clear, set wins
  assign cause_set = {sw_rst_r, watchdog_reset_i, pin_rst_req, 1'b0};
  assign cause_clr = (commit && avs_address_i == OFS_STATUS) ?
                     wmerge[ST_CAUSE_LSB +: CAUSE_W] : '0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cause_r <= CAUSE_RST;
    end else begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  // Input routing

  assign fault_raw = (func_r[TIMER_PIN] == FUNC_FAULT) &&
                     (port_a_pin_i[TIMER_PIN] == FAULT_ACTIVE);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_in_r <= 8'h00;
    end else begin
      data_in_r              <= {3'h0, port_a_pin_i};
      data_in_r[RST_PIN_BIT] <= reset_pin_port_bit_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_st_r                <= 1'b0;
      offchip_fault_input_one_o <= 1'b0;
      pulse_fault_o             <= '0;
    end else begin
      fault_st_r                <= fault_raw;
      offchip_fault_input_one_o <= fault_raw;
      pulse_fault_o             <= fault_raw ? fault_map_r : '0;
    end
  end

  // Timer sees the pad only while bit 4 is in its timer role
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_a_channel_two_in_o <= 1'b0;
    end else begin
      timer_a_channel_two_in_o <= (func_r[TIMER_PIN] == FUNC_TIMER) &&
                                  port_a_pin_i[TIMER_PIN];
    end
  end

  // Output drivers, one per low port A pin

  // Timer and fault codes are only meaningful on bit 4; elsewhere they act as GPIO
  for (genvar k = 0; k < LOW_PINS; k++) begin : g_pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        port_a_pin_o[k]      <= 1'b0;
        port_a_pin_oe_n_o[k] <= 1'b1;
      end else begin
        unique case (func_r[k])
          FUNC_PULSE: begin
            port_a_pin_o[k]      <= pulse_out_i[k] && !(fault_raw && fault_map_r[k]);
            port_a_pin_oe_n_o[k] <= 1'b0;
          end
          FUNC_TIMER: begin
            if (k == TIMER_PIN) begin
              port_a_pin_o[k]      <= timer_a_channel_two_out_i;
              port_a_pin_oe_n_o[k] <= !timer_a_channel_two_oe_i;
            end else begin
              port_a_pin_o[k]      <= data_out_r[k];
              port_a_pin_oe_n_o[k] <= !dir_r[k];
            end
          end
          FUNC_FAULT: begin
            if (k == TIMER_PIN) begin
              port_a_pin_o[k]      <= 1'b0;
              port_a_pin_oe_n_o[k] <= 1'b1;
            end else begin
              port_a_pin_o[k]      <= data_out_r[k];
              port_a_pin_oe_n_o[k] <= !dir_r[k];
            end
          end
          FUNC_GPIO: begin
            port_a_pin_o[k]      <= data_out_r[k];
            port_a_pin_oe_n_o[k] <= !dir_r[k];
          end
        endcase
      end
    end
  end

  // Reset pin as GPIO can only pull low, never drive high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_pin_port_bit_o      <= 1'b0;
      reset_pin_port_bit_oe_n_o <= 1'b1;
    end else begin
      reset_pin_port_bit_o      <= 1'b0;
      reset_pin_port_bit_oe_n_o <= !(cfg_gpio_r && dir_r[RST_PIN_BIT] &&
                                     !data_out_r[RST_PIN_BIT]);
    end
  end

endmodule

`default_nettype wire

// ### bench/pin_select_monitor.sv
// Concurrent checks on the pin select block's ports.
// Assumes one clock domain and one wait state on every bus access.
`timescale 1ns/10ps
`default_nettype none

module pin_select_monitor (
  // Clock and reset
  input wire logic                               clk_i,
  input wire logic                               arst_n_i,
  // Bus
  input wire logic                               avs_read_i,
  input wire logic                               avs_write_i,
  input wire logic [31:0]                        avs_readdata_o,
  input wire logic                               avs_waitrequest_o,
  // Reset pin and resets
  input wire logic                               reset_pin_port_bit_o,
  input wire logic                               reset_pin_port_bit_oe_n_o,
  input wire logic                               watchdog_reset_i,
  input wire logic                               sys_rst_n_o,
  // Port pins and fault
  input wire logic [pin_select_pkg::LOW_PINS-1:0] port_a_pin_oe_n_o,
  input wire logic [pin_select_pkg::PULSE_CH-1:0] pulse_fault_o,
  input wire logic                               offchip_fault_input_one_o
);
  import pin_select_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without request");
  a_rdata_hold: assert property (avs_waitrequest_o |-> $stable(avs_readdata_o))
    else $error("read data moved while waiting");
  a_pin_open_drain: assert property (reset_pin_port_bit_o == 1'b0)
    else $error("reset pin drives high");
  a_wdog_resets: assert property (watchdog_reset_i |-> ##[1:3] !sys_rst_n_o)
    else $error("watchdog did not reset");
  a_release_quiet: assert property ($rose(sys_rst_n_o) |-> !watchdog_reset_i &&
    !$past(watchdog_reset_i) && !$past(watchdog_reset_i, 2)) else $error("early release");
  a_reset_inputs: assert property (!sys_rst_n_o [*4] |-> (&port_a_pin_oe_n_o) &&
    reset_pin_port_bit_oe_n_o) else $error("pin driven in reset");
  a_fault_gate: assert property (|pulse_fault_o |-> offchip_fault_input_one_o)
    else $error("pulse fault without fault");

  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_release: cover property ($rose(sys_rst_n_o));
  c_fault: cover property (offchip_fault_input_one_o);
  c_od_low: cover property (!reset_pin_port_bit_oe_n_o);
endmodule

bind reset_and_port_a_pin_select pin_select_monitor i_mon (
  .clk_i                     (clk_i),
  .arst_n_i                  (arst_n_i),
  .avs_read_i                (avs_read_i),
  .avs_write_i               (avs_write_i),
  .avs_readdata_o            (avs_readdata_o),
  .avs_waitrequest_o         (avs_waitrequest_o),
  .reset_pin_port_bit_o      (reset_pin_port_bit_o),
  .reset_pin_port_bit_oe_n_o (reset_pin_port_bit_oe_n_o),
  .watchdog_reset_i          (watchdog_reset_i),
  .sys_rst_n_o               (sys_rst_n_o),
  .port_a_pin_oe_n_o         (port_a_pin_oe_n_o),
  .pulse_fault_o             (pulse_fault_o),
  .offchip_fault_input_one_o (offchip_fault_input_one_o)
);
`default_nettype wire

// ### bench/board_pins.sv
// Board side of the pads: pull-ups, external drivers, open-drain reset pin.
// Assumes the design's enables are active low.
`timescale 1ns/10ps
`default_nettype none

module board_pins (
  // Design side
  input  wire logic [pin_select_pkg::LOW_PINS-1:0] pin_o,
  input  wire logic [pin_select_pkg::LOW_PINS-1:0] pin_oe_n,
  input  wire logic                               rst_o,
  input  wire logic                               rst_oe_n,
  // External drivers
  input  wire logic [pin_select_pkg::LOW_PINS-1:0] ext_drv,
  input  wire logic [pin_select_pkg::LOW_PINS-1:0] ext_lvl,
  input  wire logic                               rst_drv,
  input  wire logic                               rst_lvl,
  // Resolved pad levels
  output logic      [pin_select_pkg::LOW_PINS-1:0] pad,
  output logic                                    rst_pad
);
  import pin_select_pkg::*;
  // Undriven pads float to the pull-up
  assign pad = (~pin_oe_n & pin_o) | (pin_oe_n & ext_drv & ext_lvl) | (pin_oe_n & ~ext_drv);
  // Only a low is ever driven on the reset pin
  assign rst_pad = (!rst_oe_n && !rst_o) ? 1'b0 : (rst_drv ? rst_lvl : 1'b1);
endmodule
`default_nettype wire

// ### bench/reset_and_port_a_pin_select_test.sv
// Self-checking bench for the pin select block.
// Assumes the board model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

module reset_and_port_a_pin_select_test;
  import pin_select_pkg::*;
  logic                clk_i = 1'b0;
  logic                arst_n_i = 1'b0;
  logic [ADDR_W-1:0]   adr = '0;
  logic                rd = 1'b0;
  logic                wr = 1'b0;
  logic [31:0]         wdat = '0;
  logic [3:0]          be = 4'hF;
  logic [31:0]         rdat;
  logic                wait_r;
  logic                rst_pad, rst_o, rst_oe_n, sys_rst_n_o, tmr_in, offchip_fault_input_one;
  logic                rst_drv = 1'b0;
  logic                rst_lvl = 1'b1;
  logic                wdog = 1'b0;
  logic                tmr_out = 1'b0;
  logic                tmr_oe = 1'b0;
  logic [LOW_PINS-1:0] pad, pin_o, pin_oe_n;
  logic [LOW_PINS-1:0] ext_drv = '0;
  logic [LOW_PINS-1:0] ext_lvl = '0;
  logic [PULSE_CH-1:0] pulse = '0;
  logic [PULSE_CH-1:0] pfault;
  int                  err_count = 0;
  int                  compares = 0;
  int                  cyc = 0;

  always #12.5 clk_i = ~clk_i;

  reset_and_port_a_pin_select #(.HOLD_CYCLES(2)) i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r), .reset_pin_port_bit_i(rst_pad),
    .reset_pin_port_bit_o(rst_o), .reset_pin_port_bit_oe_n_o(rst_oe_n),
    .watchdog_reset_i(wdog), .sys_rst_n_o(sys_rst_n_o), .port_a_pin_i(pad),
    .port_a_pin_o(pin_o), .port_a_pin_oe_n_o(pin_oe_n), .pulse_out_i(pulse),
    .pulse_fault_o(pfault), .timer_a_channel_two_out_i(tmr_out),
    .timer_a_channel_two_oe_i(tmr_oe), .timer_a_channel_two_in_o(tmr_in),
    .offchip_fault_input_one_o(offchip_fault_input_one));

  board_pins i_board (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .rst_o(rst_o),
    .rst_oe_n(rst_oe_n), .ext_drv(ext_drv), .ext_lvl(ext_lvl), .rst_drv(rst_drv),
    .rst_lvl(rst_lvl), .pad(pad), .rst_pad(rst_pad));

  task give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b,
           output logic [31:0] q);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    adr <= a;
    wdat <= d;
    be <= b;
    do @(posedge clk_i); while (wait_r !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task wrr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task rdc(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, 4'hF, q);
    chk(nm, e, q & m);
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task wait_sys;
    int n;
    n = 0;
    while (sys_rst_n_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("sys_up", 1, sys_rst_n_o);
  endtask

  task t_defaults;
    rdc("dir", OFS_DIR, 32'hFF, {24'h0, DIR_RST});
    rdc("func", OFS_FUNC_SEL, 32'h3FF, 32'h0);
    rdc("rcfg", OFS_RST_PIN_CFG, 32'h1, 32'h0);
    rdc("fmap", OFS_FAULT_MAP, 32'h3F, 32'h0);
    rdc("cause", OFS_STATUS, 32'hF0, 32'h10);
    settle(0);
    chk("oe_n", 32'h3F, {26'h0, rst_oe_n, pin_oe_n});
  endtask

  task t_gpio;
    logic [31:0] q;
    @(posedge clk_i);
    pulse <= 6'h3F;
    wrr(OFS_DIR, 32'h05);
    wrr(OFS_DATA_OUT, 32'h19);
    settle(2);
    chk("oe_n", 32'h1A, pin_oe_n);
    chk("out", 32'h01, pin_o & 5'h05);
    @(posedge clk_i);
    ext_drv <= 5'h0A;
    ext_lvl <= 5'h02;
    rdc("din", OFS_DATA_IN, 32'h1F, 32'h13);
    bus(1'b1, OFS_DIR, 32'h1F, 4'h0, q);
    rdc("dir_be", OFS_DIR, 32'h9F, 32'h05);
    wrr(OFS_DIR, 32'h00);
    ext_drv <= 5'h00;
  endtask

  task t_pulse;
    pulse <= 6'h35;
    wrr(OFS_FUNC_SEL, 32'h155);
    settle(2);
    chk("oe_n", 32'h0, pin_oe_n);
    chk("out", 32'h15, pin_o);
    @(posedge clk_i);
    pulse <= 6'h0A;
    settle(2);
    chk("out", 32'h0A, pin_o);
    wrr(OFS_FUNC_SEL, 32'h0);
  endtask

  task t_timer;
    tmr_out <= 1'b1;
    tmr_oe <= 1'b1;
    wrr(OFS_FUNC_SEL, 32'h200);
    settle(2);
    chk("tmr_oe", 0, pin_oe_n[4]);
    chk("tmr_o", 1, pin_o[4]);
    @(posedge clk_i);
    tmr_oe <= 1'b0;
    ext_drv <= 5'h10;
    settle(2);
    chk("tmr_oe", 1, pin_oe_n[4]);
    chk("tmr_in", 0, tmr_in);
    @(posedge clk_i);
    ext_lvl <= 5'h10;
    settle(2);
    chk("tmr_in", 1, tmr_in);
  endtask

  task t_fault;
    wrr(OFS_FAULT_MAP, 32'h0F);
    wrr(OFS_FUNC_SEL, 32'h355);
    settle(2);
    chk("fault", 1, offchip_fault_input_one);
    chk("pfault", 32'h0F, pfault);
    chk("gated", 32'h0, pin_o[3:0]);
    rdc("st_fault", OFS_STATUS, 32'h1, 32'h1);
    @(posedge clk_i);
    ext_lvl <= 5'h00;
    settle(2);
    chk("pfault", 32'h0, pfault);
    chk("ungated", 32'h0A, pin_o[3:0]);
    wrr(OFS_FUNC_SEL, 32'h0);
    ext_drv <= 5'h00;
  endtask

  task t_resets;
    wrr(OFS_STATUS, 32'hF0);
    wrr(OFS_DIR, 32'h80);
    rst_drv <= 1'b1;
    rst_lvl <= 1'b0;
    settle(4);
    chk("sys_pin", 0, sys_rst_n_o);
    @(posedge clk_i);
    rst_drv <= 1'b0;
    settle(1);
    chk("sys_hold", 0, sys_rst_n_o);
    wait_sys;
    rdc("dir_clr", OFS_DIR, 32'hFF, 32'h0);
    rdc("cause_pin", OFS_STATUS, 32'hF0, 32'h20);
    wrr(OFS_RST_PIN_CFG, 32'h1);
    wrr(OFS_DIR, 32'h80);
    wrr(OFS_DATA_OUT, 32'h00);
    settle(4);
    chk("od_oe", 0, rst_oe_n);
    chk("sys_gpio", 1, sys_rst_n_o);
    wrr(OFS_DATA_OUT, 32'h80);
    rst_drv <= 1'b1;
    settle(4);
    chk("od_rel", 1, rst_oe_n);
    chk("sys_ext", 1, sys_rst_n_o);
    rdc("din7", OFS_DATA_IN, 32'h80, 32'h0);
    wdog <= 1'b1;
    settle(3);
    chk("sys_wdog", 0, sys_rst_n_o);
    @(posedge clk_i);
    wdog <= 1'b0;
    rst_drv <= 1'b0;
    wait_sys;
    rdc("rcfg", OFS_RST_PIN_CFG, 32'h1, 32'h0);
    rdc("cause_wd", OFS_STATUS, 32'h40, 32'h40);
    wrr(OFS_SW_RESET, 32'h1);
    settle(2);
    chk("sys_sw", 0, sys_rst_n_o);
    wait_sys;
    rdc("cause_sw", OFS_STATUS, 32'h80, 32'h80);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait_sys;
    t_defaults;
    t_gpio;
    t_pulse;
    t_timer;
    t_fault;
    t_resets;
    give_verdict;
  end
endmodule
`default_nettype wire
